// *** core/sfo_pkg.sv ***
// constants, state type and configuration layout of the safety output block
// assumes one 40 MHz clock shared with the device state machine
package sfo_pkg;
	typedef enum logic [2:0] {ST_OFF, ST_RESET, ST_DIAG, ST_ACTIVE, ST_SAFE} sfo_state_e;

	localparam int CLK_MHZ = 40;
	// reset extension times per reset_stretch_sel code, in microseconds
	localparam int STRETCH_US_0 = 200;
	localparam int STRETCH_US_1 = 1000;
	localparam int STRETCH_US_2 = 4000;
	localparam int STRETCH_US_3 = 10000;
	localparam int STRETCH_CYC_0 = STRETCH_US_0 * CLK_MHZ;
	localparam int STRETCH_CYC_1 = STRETCH_US_1 * CLK_MHZ;
	localparam int STRETCH_CYC_2 = STRETCH_US_2 * CLK_MHZ;
	localparam int STRETCH_CYC_3 = STRETCH_US_3 * CLK_MHZ;
	localparam int STRETCH_W = 20;

	// protected configuration store, scanned in index order
	localparam int CFG_N = 16;
	localparam int CFG_AW = 4;
	localparam logic [3:0] IDX_DEVICE_CONFIG4 = 4'h3;
	localparam logic [3:0] IDX_SAFE_CFG1 = 4'h4;
	localparam logic [3:0] IDX_SAFE_CFG2 = 4'h5;
	localparam logic [3:0] IDX_SAFE_CFG3 = 4'h6;
	localparam logic [3:0] IDX_SAFE_CFG4 = 4'h7;
	localparam logic [3:0] IDX_SAFE_CFG5 = 4'h8;
	localparam logic [3:0] IDX_SAFE_CFG6 = 4'h9;
	// field positions
	localparam int POS_STRETCH_SEL = 0;
	localparam int POS_PM_RST_EN = 0;
	localparam int POS_PM_SAFE_EN = 1;
	localparam int POS_WD_EN_TH = 4;
	localparam int POS_OT_IRQ_EN = 0;
	localparam int POS_EM_RST_EN = 3;
	localparam int POS_WD_RST_EN = 4;
	localparam int POS_EM_RST_TH = 0;
	localparam int POS_EM_EN_TH = 4;
	localparam int POS_WD_RST_TH = 0;
	localparam int EVT_N = 9;
	localparam logic [7:0] SAFE_CFG2_RST = 8'h50;
	localparam logic [7:0] CFG_OTHER_RST = 8'h00;

	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam logic [7:0] CRC_EXP_RST = 8'h00;
endpackage : sfo_pkg

// *** core/sfo_cfg_mem.sv ***
// configuration byte store with one write port and a registered read port
// assumes writes are already filtered by the caller
`timescale 1ns/1ps
module sfo_cfg_mem #(
	parameter int N = sfo_pkg::CFG_N,
	parameter int AW = sfo_pkg::CFG_AW
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_idx,
	input wire logic [7:0] wr_data,
	// scan read port
	input wire logic [AW-1:0] rd_idx,
	output logic [7:0] rd_data_ff,
	// all bytes, flat
	output logic [N*8-1:0] cfg_flat
);
	import sfo_pkg::*;
	logic [7:0] mem_ff [N];

	initial begin
		if (N > (1 << AW)) $error("sfo_cfg_mem: N exceeds address range");
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				mem_ff[i] <= (i == int'(IDX_SAFE_CFG2)) ? SAFE_CFG2_RST : CFG_OTHER_RST;
			end
		end else if (wr_en) begin
			mem_ff[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_ff <= 8'h00;
		end else begin
			rd_data_ff <= mem_ff[rd_idx];
		end
	end

	for (genvar g = 0; g < N; g++) begin : g_flat
		assign cfg_flat[g*8 +: 8] = mem_ff[g];
	end
endmodule : sfo_cfg_mem

// *** core/sfo_crc8.sv ***
// byte-wise crc-8 engine, msb first, inverted result per pass
// assumes first and last mark the bytes of one pass
`timescale 1ns/1ps
module sfo_crc8 (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// byte stream
	input wire logic byte_vld,
	input wire logic byte_first,
	input wire logic byte_last,
	input wire logic [7:0] byte_data,
	// result
	output logic done_ff,
	output logic [7:0] result_ff
);
	import sfo_pkg::*;
	logic [7:0] crc_ff;
	logic [7:0] nxt_crc;

	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = r[7] ^ d[i] ? {r[6:0], 1'b0} ^ CRC_POLY : {r[6:0], 1'b0};
		end
		return r;
	endfunction : crc_step

	assign nxt_crc = crc_step(byte_first ? CRC_INIT : crc_ff, byte_data);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_ff <= CRC_INIT;
		end else if (byte_vld) begin
			crc_ff <= nxt_crc;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_ff <= 1'b0;
			result_ff <= 8'h00;
		end else begin
			done_ff <= byte_vld && byte_last;
			if (byte_vld && byte_last) begin
				result_ff <= ~nxt_crc;
			end
		end
	end
endmodule : sfo_crc8

// *** core/sfo_safety_out.sv ***
// safety outputs: host reset driver with extension, enable/irq driver,
// pin readback checks and configuration crc watch
// assumes dev_state and monitor inputs come from logic on ref_clk
`timescale 1ns/1ps
// How it works
// - reset stays low in OFF state
// - reset pin is open drain, pull low only
// - reset on power-on, OFF and RESET states
// - main buck undervoltage always resets
// - other faults reset only when enabled
// - enabled watchdog count above threshold resets
// - enabled error monitor count above threshold resets
// - software reset command resets
// - external pull low with enable is warm reset
// - hold reset for selected extension after clear
// - readback versus drive mismatch sets flag
// - mismatch may request SAFE when enabled
// - enable output only high in DIAG/ACTIVE
// - watchdog below threshold, then host enables
// - flag enable output read low while high
// - self test forces enable low when overtemp_warn_irq_en is nonzero, nothing else
// - error count above enable threshold may reset
// - crc scans config while enabled
// - crc mismatch flags, and requests SAFE in RESET/DIAG/ACTIVE only
// - crc setup in DIAG, no writes in ACTIVE
// - crc-8 poly 07, init ff, msb first, inverted
// - crc covers the sixteen protected registers
// - watchdog enable threshold resets to five
module sfo_safety_out #(
	parameter int STRETCH_CYC_0 = sfo_pkg::STRETCH_CYC_0,
	parameter int STRETCH_CYC_1 = sfo_pkg::STRETCH_CYC_1,
	parameter int STRETCH_CYC_2 = sfo_pkg::STRETCH_CYC_2,
	parameter int STRETCH_CYC_3 = sfo_pkg::STRETCH_CYC_3
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// device state and events
	input sfo_pkg::sfo_state_e dev_state,
	input wire logic power_on_reset_event,
	input wire logic main_buck_uv,
	input wire logic [sfo_pkg::EVT_N-1:0] mon_fault,
	input wire logic sw_reset_cmd,
	input wire logic self_test_pulse,
	// failure counters
	input wire logic [3:0] wdog_fail_cnt,
	input wire logic [3:0] err_monitor_fail_cnt,
	// configuration writes
	input wire logic cfg_wr,
	input wire logic [sfo_pkg::CFG_AW-1:0] cfg_wr_idx,
	input wire logic [7:0] cfg_wr_data,
	output logic cfg_wr_rejected_ff,
	// crc setup and host enable commands
	input wire logic crc_setup_wr,
	input wire logic crc_setup_enable,
	input wire logic [7:0] crc_setup_expected,
	input wire logic drive_enable_set,
	input wire logic drive_enable_clr,
	input wire logic status_clr,
	// host reset pin
	input wire logic reset_pin_readback,
	output logic host_reset_out,
	output logic host_reset_oe,
	// enable/irq pin
	input wire logic enable_irq_readback,
	output logic enable_irq_out,
	// status and requests
	output logic pin_mismatch_flag,
	output logic enable_drv_err_flag,
	output logic cfg_crc_mismatch,
	output logic cfg_crc_enable,
	output logic drive_enable_ctl,
	output logic req_safe_ff,
	output logic req_reset_ff
);
	import sfo_pkg::*;

	initial begin
		// below two cycles the release would follow the clear with under two cycles of extension
		if (STRETCH_CYC_0 < 2 || STRETCH_CYC_0 >= (1 << STRETCH_W)) $error("sfo_safety_out: bad stretch count");
		if (STRETCH_CYC_1 < 2 || STRETCH_CYC_1 >= (1 << STRETCH_W)) $error("sfo_safety_out: bad stretch count");
		if (STRETCH_CYC_2 < 2 || STRETCH_CYC_2 >= (1 << STRETCH_W)) $error("sfo_safety_out: bad stretch count");
		if (STRETCH_CYC_3 < 2 || STRETCH_CYC_3 >= (1 << STRETCH_W)) $error("sfo_safety_out: bad stretch count");
	end

	function automatic logic above(input logic [3:0] cnt, input logic [3:0] th);
		return cnt > th;
	endfunction : above

	// configuration fields
	logic [CFG_N*8-1:0] cfg_flat;
	logic [7:0] scan_data;
	logic [1:0] reset_stretch_sel;
	logic pin_mismatch_reset_en;
	logic pin_mismatch_safe_en;
	logic [3:0] wdog_fail_enable_thresh;
	logic [2:0] overtemp_warn_irq_en;
	logic err_monitor_reset_en;
	logic wdog_reset_en;
	logic [3:0] err_monitor_reset_thresh;
	logic [3:0] err_monitor_enable_thresh;
	logic [3:0] wdog_reset_thresh;
	logic [EVT_N-1:0] global_reset_en;

	assign reset_stretch_sel = cfg_flat[IDX_DEVICE_CONFIG4*8 + POS_STRETCH_SEL +: 2];
	assign pin_mismatch_reset_en = cfg_flat[IDX_SAFE_CFG2*8 + POS_PM_RST_EN];
	assign pin_mismatch_safe_en = cfg_flat[IDX_SAFE_CFG2*8 + POS_PM_SAFE_EN];
	assign wdog_fail_enable_thresh = cfg_flat[IDX_SAFE_CFG2*8 + POS_WD_EN_TH +: 4];
	assign overtemp_warn_irq_en = cfg_flat[IDX_SAFE_CFG1*8 + POS_OT_IRQ_EN +: 3];
	assign err_monitor_reset_en = cfg_flat[IDX_SAFE_CFG1*8 + POS_EM_RST_EN];
	assign wdog_reset_en = cfg_flat[IDX_SAFE_CFG1*8 + POS_WD_RST_EN];
	assign err_monitor_reset_thresh = cfg_flat[IDX_SAFE_CFG3*8 + POS_EM_RST_TH +: 4];
	assign err_monitor_enable_thresh = cfg_flat[IDX_SAFE_CFG3*8 + POS_EM_EN_TH +: 4];
	assign wdog_reset_thresh = cfg_flat[IDX_SAFE_CFG4*8 + POS_WD_RST_TH +: 4];
	assign global_reset_en = cfg_flat[IDX_SAFE_CFG5*8 +: EVT_N];

	// configuration writes refused while ACTIVE
	logic cfg_wr_ok;
	assign cfg_wr_ok = cfg_wr && dev_state != ST_ACTIVE;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_wr_rejected_ff <= 1'b0;
		end else begin
			cfg_wr_rejected_ff <= cfg_wr && !cfg_wr_ok;
		end
	end

	// pin synchronisers
	logic [1:0] pin_meta_ff;
	logic [1:0] pin_sync_ff;
	logic [1:0] pin_raw;
	logic rst_pin_s;
	logic en_pin_s;
	assign pin_raw = {enable_irq_readback, reset_pin_readback};
	for (genvar g = 0; g < 2; g++) begin : g_sync
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				pin_meta_ff[g] <= 1'b0;
				pin_sync_ff[g] <= 1'b0;
			end else begin
				pin_meta_ff[g] <= pin_raw[g];
				pin_sync_ff[g] <= pin_meta_ff[g];
			end
		end
	end
	assign rst_pin_s = pin_sync_ff[0];
	assign en_pin_s = pin_sync_ff[1];

	// reset conditions
	logic por_pend_ff;
	logic reset_pin_drive;
	logic [1:0] drive_dly_ff;
	logic warm_reset;
	logic reset_cond;
	logic wd_reset;
	logic em_reset;
	logic em_enable_reset;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			por_pend_ff <= 1'b1;
		end else begin
			por_pend_ff <= 1'b0;
		end
	end

	assign warm_reset = !rst_pin_s && drive_dly_ff[1] && pin_mismatch_reset_en;
	assign wd_reset = wdog_reset_en && above(wdog_fail_cnt, wdog_reset_thresh);
	assign em_reset = err_monitor_reset_en && above(err_monitor_fail_cnt, err_monitor_reset_thresh);
	assign em_enable_reset = dev_state == ST_ACTIVE && err_monitor_reset_en
		&& above(err_monitor_fail_cnt, err_monitor_enable_thresh)
		&& err_monitor_reset_thresh <= err_monitor_enable_thresh;
	assign reset_cond = por_pend_ff || power_on_reset_event
		|| dev_state == ST_OFF || dev_state == ST_RESET
		|| main_buck_uv
		|| |(mon_fault & global_reset_en)
		|| wd_reset || em_reset || em_enable_reset
		|| sw_reset_cmd
		|| warm_reset;

	// reset extension
	logic [STRETCH_W-1:0] stretch_cnt_ff;
	logic [STRETCH_W-1:0] stretch_load;
	always_comb begin
		case (reset_stretch_sel)
			2'd0: stretch_load = STRETCH_W'(STRETCH_CYC_0);
			2'd1: stretch_load = STRETCH_W'(STRETCH_CYC_1);
			2'd2: stretch_load = STRETCH_W'(STRETCH_CYC_2);
			default: stretch_load = STRETCH_W'(STRETCH_CYC_3);
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stretch_cnt_ff <= '0;
		end else if (reset_cond) begin
			stretch_cnt_ff <= stretch_load;
		end else if (stretch_cnt_ff != '0) begin
			stretch_cnt_ff <= stretch_cnt_ff - 1'b1;
		end
	end

	// drive level: 1 releases, 0 pulls low
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_pin_drive <= 1'b0;
		end else begin
			reset_pin_drive <= !reset_cond && stretch_cnt_ff == '0;
		end
	end

	assign host_reset_out = 1'b0;
	assign host_reset_oe = !reset_pin_drive;

	// drive delayed to line up with synchronised readback
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_dly_ff <= 2'b00;
		end else begin
			drive_dly_ff <= {drive_dly_ff[0], reset_pin_drive};
		end
	end

	logic pin_mismatch;
	assign pin_mismatch = rst_pin_s != drive_dly_ff[1];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_mismatch_flag <= 1'b0;
		end else if (pin_mismatch) begin
			pin_mismatch_flag <= 1'b1;
		end else if (status_clr) begin
			pin_mismatch_flag <= 1'b0;
		end
	end

	// enable/irq gating
	logic wdog_ok_ff;
	logic en_state;
	logic en_drive;
	logic [1:0] en_dly_ff;
	assign en_state = dev_state == ST_DIAG || dev_state == ST_ACTIVE;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdog_ok_ff <= 1'b0;
		end else begin
			wdog_ok_ff <= wdog_fail_cnt < wdog_fail_enable_thresh;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_enable_ctl <= 1'b0;
		end else if (drive_enable_clr || !en_state || !wdog_ok_ff) begin
			drive_enable_ctl <= 1'b0;
		end else if (drive_enable_set) begin
			drive_enable_ctl <= 1'b1;
		end
	end

	assign en_drive = en_state && drive_enable_ctl && wdog_ok_ff
		&& !(self_test_pulse && |overtemp_warn_irq_en);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_irq_out <= 1'b0;
		end else begin
			enable_irq_out <= en_drive;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_dly_ff <= 2'b00;
		end else begin
			en_dly_ff <= {en_dly_ff[0] && enable_irq_out, enable_irq_out};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_drv_err_flag <= 1'b0;
		end else if (en_dly_ff[1] && enable_irq_out && !en_pin_s) begin
			enable_drv_err_flag <= 1'b1;
		end else if (status_clr) begin
			enable_drv_err_flag <= 1'b0;
		end
	end

	// crc setup, DIAG only
	logic [7:0] cfg_crc_expected;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_crc_enable <= 1'b0;
			cfg_crc_expected <= CRC_EXP_RST;
		end else if (crc_setup_wr && dev_state == ST_DIAG) begin
			cfg_crc_enable <= crc_setup_enable;
			cfg_crc_expected <= crc_setup_expected;
		end
	end

	// crc scan over the store
	logic [CFG_AW-1:0] scan_idx_ff;
	logic [CFG_AW-1:0] rd_idx_ff;
	logic rd_vld_ff;
	logic crc_done;
	logic [7:0] crc_result;
	logic scan_restart;
	assign scan_restart = !cfg_crc_enable || cfg_wr_ok || crc_setup_wr;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_idx_ff <= '0;
			rd_idx_ff <= '0;
			rd_vld_ff <= 1'b0;
		end else if (scan_restart) begin
			scan_idx_ff <= '0;
			rd_vld_ff <= 1'b0;
		end else begin
			scan_idx_ff <= scan_idx_ff + 1'b1;
			rd_idx_ff <= scan_idx_ff;
			rd_vld_ff <= 1'b1;
		end
	end

	sfo_cfg_mem u_mem (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(cfg_wr_ok),
		.wr_idx(cfg_wr_idx),
		.wr_data(cfg_wr_data),
		.rd_idx(scan_idx_ff),
		.rd_data_ff(scan_data),
		.cfg_flat(cfg_flat)
	);

	sfo_crc8 u_crc (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.byte_vld(rd_vld_ff && !scan_restart),
		.byte_first(rd_idx_ff == '0),
		.byte_last(rd_idx_ff == CFG_AW'(CFG_N - 1)),
		.byte_data(scan_data),
		.done_ff(crc_done),
		.result_ff(crc_result)
	);

	logic crc_bad;
	assign crc_bad = crc_done && cfg_crc_enable && crc_result != cfg_crc_expected;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_crc_mismatch <= 1'b0;
		end else if (crc_bad) begin
			cfg_crc_mismatch <= 1'b1;
		end else if (status_clr) begin
			cfg_crc_mismatch <= 1'b0;
		end
	end

	// state change requests to the device state machine
	logic crc_safe;
	logic pin_safe;
	assign crc_safe = crc_bad && (dev_state == ST_RESET || en_state);
	assign pin_safe = pin_mismatch && pin_mismatch_safe_en && !pin_mismatch_reset_en;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_safe_ff <= 1'b0;
			req_reset_ff <= 1'b0;
		end else begin
			req_safe_ff <= crc_safe || pin_safe;
			req_reset_ff <= em_enable_reset;
		end
	end

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence seq_en_high;
		enable_irq_out ##1 enable_irq_out ##1 enable_irq_out;
	endsequence
	sequence seq_cond_gone;
		reset_cond ##1 !reset_cond;
	endsequence

	chk_off_holds: assert property (dev_state == ST_OFF |=> host_reset_oe)
		else $error("reset released in OFF");
	chk_main_uv: assert property (main_buck_uv |=> host_reset_oe && !reset_pin_drive)
		else $error("main buck uv did not reset");
	chk_stretch_hold: assert property (seq_cond_gone |=> host_reset_oe[*2])
		else $error("reset extension missing");
	chk_sw_reset: assert property (sw_reset_cmd |=> host_reset_oe)
		else $error("software reset ignored");
	chk_pin_flag: assert property (rst_pin_s != drive_dly_ff[1] |=> pin_mismatch_flag)
		else $error("pin mismatch not flagged");
	chk_pin_safe: assert property (pin_safe |=> req_safe_ff)
		else $error("pin mismatch safe request missing");
	chk_en_state: assert property (enable_irq_out |-> $past(en_state))
		else $error("enable high outside diag/active");
	chk_en_order: assert property ($rose(drive_enable_ctl) |-> $past(wdog_ok_ff) && $past(drive_enable_set))
		else $error("enable set out of order");
	chk_drv_err: assert property (seq_en_high ##0 !en_pin_s |=> enable_drv_err_flag)
		else $error("enable driver error missed");
	chk_self_test: assert property (self_test_pulse && |overtemp_warn_irq_en && drive_enable_ctl
		|=> !enable_irq_out && drive_enable_ctl)
		else $error("self test did not force enable low");
	chk_crc_safe: assert property (crc_bad && dev_state != ST_OFF && dev_state != ST_SAFE
		|=> cfg_crc_mismatch && req_safe_ff)
		else $error("crc mismatch not handled");
	chk_active_wr: assert property (cfg_wr && dev_state == ST_ACTIVE |=> $stable(cfg_flat) && cfg_wr_rejected_ff)
		else $error("config written in ACTIVE");
	chk_crc_setup: assert property (crc_setup_wr && dev_state != ST_DIAG |=> $stable(cfg_crc_enable))
		else $error("crc setup outside DIAG");
endmodule : sfo_safety_out

// *** test/sfo_host_model.sv ***
// host side model: reset line with pullup, enable line with a load
// assumes the bench commands when the host pulls a line low
`timescale 1ns/1ps
module sfo_host_model (
	// device pins
	input wire logic host_reset_oe,
	input wire logic enable_irq_out,
	output logic reset_pin_readback,
	output logic enable_irq_readback,
	// host pulls
	input wire logic pull_reset,
	input wire logic pull_enable
);
	assign reset_pin_readback = !(host_reset_oe || pull_reset);
	assign enable_irq_readback = enable_irq_out && !pull_enable;
endmodule : sfo_host_model

// *** test/sfo_safety_out_tb.sv ***
// self-checking bench for the safety output block
// assumes short stretch counts 4/6/8/10 and the host model on the pins
`timescale 1ns/1ps
module sfo_safety_out_tb;
	import sfo_pkg::*;
	typedef struct {int idx; logic val;} sfo_exp_s;
	localparam int STR[4] = '{4, 6, 8, 10};
	logic ref_clk = 0;
	logic rst_n = 0;
	sfo_state_e dev_state = ST_OFF;
	logic por = 0, buv = 0, swr = 0, stp = 0, cw = 0, csw = 0, cse = 0;
	logic des = 0, dec = 0, sc = 0, pr = 0, pe = 0;
	logic [8:0] mf = '0;
	logic [3:0] wdc = 4'h0, emc = 4'h0, ci = 4'h0;
	logic [7:0] cd = 8'h00, cx = 8'h00;
	logic rb, eb, ro, oe, eo, pmf, edf, ccm, cce, dctl, rs, rr, rej;
	logic [7:0] cfg [16];
	int err_count = 0;
	int n_checks = 0;
	sfo_exp_s exq[$];
	event obs_ev;
	wire logic [10:0] obs = {ro, cce, rr, rs, rej, ccm, edf, dctl, pmf, eo, oe};

	sfo_safety_out #(.STRETCH_CYC_0(4), .STRETCH_CYC_1(6), .STRETCH_CYC_2(8), .STRETCH_CYC_3(10)) DUT (
		.ref_clk(ref_clk), .rst_n(rst_n), .dev_state(dev_state), .power_on_reset_event(por),
		.main_buck_uv(buv), .mon_fault(mf), .sw_reset_cmd(swr), .self_test_pulse(stp),
		.wdog_fail_cnt(wdc), .err_monitor_fail_cnt(emc), .cfg_wr(cw), .cfg_wr_idx(ci),
		.cfg_wr_data(cd), .cfg_wr_rejected_ff(rej), .crc_setup_wr(csw), .crc_setup_enable(cse),
		.crc_setup_expected(cx), .drive_enable_set(des), .drive_enable_clr(dec), .status_clr(sc),
		.reset_pin_readback(rb), .host_reset_out(ro), .host_reset_oe(oe), .enable_irq_readback(eb),
		.enable_irq_out(eo), .pin_mismatch_flag(pmf), .enable_drv_err_flag(edf),
		.cfg_crc_mismatch(ccm), .cfg_crc_enable(cce), .drive_enable_ctl(dctl),
		.req_safe_ff(rs), .req_reset_ff(rr));
	sfo_host_model host (.host_reset_oe(oe), .enable_irq_out(eo), .reset_pin_readback(rb),
		.enable_irq_readback(eb), .pull_reset(pr), .pull_enable(pe));

	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	// note an expectation; the monitor samples it mid-cycle
	task automatic expect_bit(input int idx, input logic val);
		exq.push_back('{idx, val});
		->obs_ev;
	endtask : expect_bit

	task automatic check_bit(input sfo_exp_s e);
		n_checks++;
		if (obs[e.idx] !== e.val) begin
			err_count++;
			$display("mismatch at %0t: output %0d is %b, expected %b", $time, e.idx, obs[e.idx], e.val);
		end
	endtask : check_bit

	initial begin
		forever begin
			@(obs_ev);
			@(negedge ref_clk);
			while (exq.size() > 0) check_bit(exq.pop_front());
		end
	end

	task automatic wr_cfg(input logic [3:0] i, input logic [7:0] d);
		// edge first: back-to-back writes never lower and raise the strobe in one step
		tick(1);
		cw <= 1;
		ci <= i;
		cd <= d;
		tick(1);
		cw <= 0;
		if (dev_state != ST_ACTIVE) cfg[i] = d;
	endtask : wr_cfg

	task automatic pulse_sw();
		swr <= 1;
		tick(1);
		swr <= 0;
		tick(1);
	endtask : pulse_sw

	function automatic logic [7:0] crc_of();
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 0; i < 16; i++) begin
			for (int b = 7; b >= 0; b--) begin
				c = {c[6:0], 1'b0} ^ ((c[7] ^ cfg[i][b]) ? 8'h07 : 8'h00);
			end
		end
		return ~c;
	endfunction : crc_of

	task automatic end_sim();
		$display("checks %0d, errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	initial begin
		#(25 * 5000);
		err_count++;
		end_sim();
	end

	initial begin
		void'($urandom(29761));
		for (int i = 0; i < 16; i++) cfg[i] = (i == 5) ? SAFE_CFG2_RST : CFG_OTHER_RST;
		tick(4);
		rst_n <= 1;
		tick(1);
		expect_bit(0, 1);
		expect_bit(10, 0);
		tick(3);
		expect_bit(0, 1);
		dev_state <= ST_DIAG;
		tick(12);
		expect_bit(0, 0);
		expect_bit(1, 0);
		for (int i = 10; i < 16; i++) wr_cfg(4'(i), 8'($urandom()));
		for (int s = 0; s < 4; s++) begin
			wr_cfg(IDX_DEVICE_CONFIG4, 8'(s));
			pulse_sw();
			expect_bit(0, 1);
			tick(STR[s] - 1);
			expect_bit(0, 1);
			tick(5);
			expect_bit(0, 0);
		end
		wr_cfg(IDX_DEVICE_CONFIG4, 8'h00);
		for (int i = 0; i < 9; i++) begin
			mf <= 9'h001 << i;
			tick(2);
			expect_bit(0, 0);
		end
		mf <= '0;
		wr_cfg(IDX_SAFE_CFG5, 8'hFF);
		wr_cfg(IDX_SAFE_CFG6, 8'h01);
		for (int i = 0; i < 9; i++) begin
			mf <= 9'h001 << i;
			tick(2);
			expect_bit(0, 1);
			mf <= '0;
			tick(10);
		end
		buv <= 1;
		tick(2);
		expect_bit(0, 1);
		buv <= 0;
		tick(10);
		por <= 1;
		tick(2);
		expect_bit(0, 1);
		por <= 0;
		dev_state <= ST_RESET;
		tick(2);
		expect_bit(0, 1);
		dev_state <= ST_DIAG;
		tick(10);
		expect_bit(0, 0);
		sc <= 1;
		tick(1);
		sc <= 0;
		pr <= 1;
		tick(5);
		expect_bit(2, 1);
		expect_bit(7, 0);
		pr <= 0;
		wr_cfg(IDX_SAFE_CFG2, 8'h52);
		pr <= 1;
		tick(5);
		expect_bit(7, 1);
		pr <= 0;
		wr_cfg(IDX_SAFE_CFG2, 8'h51);
		tick(4);
		pr <= 1;
		tick(2);
		pr <= 0;
		tick(3);
		expect_bit(0, 1);
		tick(12);
		wr_cfg(IDX_SAFE_CFG2, 8'h50);
		wr_cfg(IDX_SAFE_CFG1, 8'h01);
		wdc <= 4'h5;
		tick(2);
		des <= 1;
		tick(1);
		des <= 0;
		tick(3);
		expect_bit(3, 0);
		wdc <= 4'h4;
		tick(2);
		des <= 1;
		tick(1);
		des <= 0;
		tick(2);
		expect_bit(3, 1);
		expect_bit(1, 1);
		stp <= 1;
		tick(2);
		expect_bit(1, 0);
		expect_bit(3, 1);
		stp <= 0;
		tick(2);
		expect_bit(1, 1);
		pe <= 1;
		tick(6);
		expect_bit(4, 1);
		pe <= 0;
		dev_state <= ST_SAFE;
		wdc <= 4'h0;
		tick(3);
		expect_bit(1, 0);
		dev_state <= ST_DIAG;
		wr_cfg(IDX_SAFE_CFG1, 8'h18);
		wr_cfg(IDX_SAFE_CFG3, 8'h33);
		wr_cfg(IDX_SAFE_CFG4, 8'h03);
		dev_state <= ST_ACTIVE;
		tick(1);
		wr_cfg(4'hF, 8'hAA);
		expect_bit(6, 1);
		emc <= 4'h4;
		tick(2);
		expect_bit(0, 1);
		expect_bit(8, 1);
		emc <= 4'h0;
		tick(10);
		expect_bit(0, 0);
		wdc <= 4'h4;
		tick(2);
		expect_bit(0, 1);
		wdc <= 4'h0;
		dev_state <= ST_DIAG;
		tick(10);
		cse <= 1;
		cx <= crc_of();
		csw <= 1;
		tick(1);
		csw <= 0;
		tick(40);
		expect_bit(5, 0);
		cx <= ~crc_of();
		csw <= 1;
		tick(1);
		csw <= 0;
		tick(40);
		expect_bit(5, 1);
		expect_bit(9, 1);
		dev_state <= ST_ACTIVE;
		cse <= 0;
		csw <= 1;
		tick(1);
		csw <= 0;
		tick(2);
		expect_bit(9, 1);
		expect_bit(10, 0);
		tick(2);
		end_sim();
	end
endmodule : sfo_safety_out_tb
